// [rtl/synth_pkg.sv]
`default_nettype none

package synth_pkg;

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int ACCUM_WIDTH  = 8;
	localparam int INDEX_WIDTH  = 4;
	localparam int SAMPLE_WIDTH = 8;
	localparam int TABLE_DEPTH  = 16;
	localparam int COUNT_WIDTH  = 16;

	localparam logic [ACCUM_WIDTH-1:0]  ACCUM_RESET = 8'h00;
	localparam logic [INDEX_WIDTH-1:0]  INDEX_RESET = 4'h0;
	localparam logic [SAMPLE_WIDTH-1:0] SUM_RESET   = 8'h00;
	localparam logic [SAMPLE_WIDTH-1:0] OE_RESET    = 8'h00;
	localparam logic [SAMPLE_WIDTH-1:0] OE_DRIVE    = 8'hFF;
	localparam logic [COUNT_WIDTH-1:0]  COUNT_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// update a, load, update b, mix, drive
	localparam int LOOP_CYCLES   = 5;
	localparam int LOOP_NS       = LOOP_CYCLES * CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// sine table: 16 steps of 22.5 degrees, 64 +/- 63
	// ----------------------------------------------------------------
	// peak 0x7F keeps the sum of two entries inside 8 bits
	localparam logic [SAMPLE_WIDTH-1:0] SINE_TABLE [TABLE_DEPTH] = '{
		8'h40, 8'h58, 8'h6D, 8'h7A, 8'h7F, 8'h7A, 8'h6D, 8'h58,
		8'h40, 8'h28, 8'h13, 8'h06, 8'h01, 8'h06, 8'h13, 8'h28
	};

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_INIT   = 3'b000,
		ST_STEP_A = 3'b001,
		ST_LOAD   = 3'b010,
		ST_STEP_B = 3'b011,
		ST_MIX    = 3'b100,
		ST_DRIVE  = 3'b101
	} seq_state_t;

	typedef struct packed {
		seq_state_t              state;
		logic [SAMPLE_WIDTH-1:0] work_sum;
		logic [SAMPLE_WIDTH-1:0] port;
		logic [SAMPLE_WIDTH-1:0] oe;
		logic                    strobe;
		logic [COUNT_WIDTH-1:0]  loops;
	} synth_state_t;

	typedef struct packed {
		logic [ACCUM_WIDTH-1:0] accum;
		logic [INDEX_WIDTH-1:0] index;
		logic                   carry;
	} chan_view_t;

endpackage : synth_pkg

`default_nettype wire

// [rtl/phase_channel.sv]
`default_nettype none

module phase_channel #(
	parameter int ACCUM_WIDTH = synth_pkg::ACCUM_WIDTH,
	parameter int INDEX_WIDTH = synth_pkg::INDEX_WIDTH
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// control
	input  wire logic                   step_en,
	input  wire logic [ACCUM_WIDTH-1:0] step_const,
	input  wire logic [INDEX_WIDTH-1:0] start_index,
	// state
	output logic      [ACCUM_WIDTH-1:0] accum,
	output logic      [INDEX_WIDTH-1:0] index,
	output logic                        carry
);

	typedef struct packed {
		logic [ACCUM_WIDTH-1:0] accum;
		logic [INDEX_WIDTH-1:0] index;
		logic                   carry;
	} chan_state_t;

	chan_state_t           s_q;
	chan_state_t           s_d;
	logic [ACCUM_WIDTH:0]  wide_sum;

	always_comb begin
		s_d      = s_q;
		// (RULE11) add wraps modulo 256
		// carry falls out of the extra top bit, wrap is modulo 2^N
		wide_sum = {1'b0, s_q.accum} + {1'b0, step_const};
		s_d.carry = 1'b0;
		if (step_en) begin
			s_d.accum = wide_sum[ACCUM_WIDTH-1:0];
			s_d.carry = wide_sum[ACCUM_WIDTH];
			// (RULE12) index wraps at table end
			if (wide_sum[ACCUM_WIDTH]) begin
				s_d.index = s_q.index + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q.accum <= ACCUM_WIDTH'(synth_pkg::ACCUM_RESET);
			// preload taken while reset is held
			s_q.index <= start_index;
			s_q.carry <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign accum = s_q.accum;
	assign index = s_q.index;
	assign carry = s_q.carry;

endmodule : phase_channel

`default_nettype wire

// [rtl/sine_synth.sv]
// How it works
// (RULE1) Each loop adds constant a to accumulator a and a carry steps index a.
// (RULE2) Each loop adds constant b to accumulator b and a carry steps index b.
// (RULE3) After channel a updates, the working sum loads table[index a].
// (RULE4) After channel b updates, table[index b] is added into the sum.
// (RULE5) The loop ends by copying the working sum to the converter port.
// (RULE6) Every loop lasts the same number of cycles whatever the carries.
// (RULE7) The table holds 16 sine amplitudes spaced 22.5 degrees apart.
// (RULE8) Start-up enables the port drivers and clears all working state; the code loads index a from START_INDEX_A instead of clearing it.
// (RULE9) Index a may start from a preset value to offset its phase.
// (RULE10) Equal constants step both indices alike, giving one pure tone.
// (RULE11) Accumulators wrap modulo 256, so a nonzero constant gives a carry every 1 to 256 loops.
// (RULE12) Each 4-bit index wraps from the last entry back to zero.
// (RULE13) Table values are scaled so two of them never overflow the port.
`default_nettype none

module sine_synth #(
	parameter int ACCUM_WIDTH  = synth_pkg::ACCUM_WIDTH,
	parameter int INDEX_WIDTH  = synth_pkg::INDEX_WIDTH,
	parameter int SAMPLE_WIDTH = synth_pkg::SAMPLE_WIDTH
) (
	// clock and reset
	input  wire logic                    REF_CLK,
	input  wire logic                    SRST,
	// tone setup
	input  wire logic [ACCUM_WIDTH-1:0]  STEP_CONST_A,
	input  wire logic [ACCUM_WIDTH-1:0]  STEP_CONST_B,
	input  wire logic [INDEX_WIDTH-1:0]  START_INDEX_A,
	// converter port
	output logic      [SAMPLE_WIDTH-1:0] DAC_OUTPUT_PORT,
	output logic      [SAMPLE_WIDTH-1:0] DAC_OUTPUT_OE,
	output logic                         SAMPLE_STROBE,
	// observation
	output logic      [INDEX_WIDTH-1:0]  TABLE_INDEX_A,
	output logic      [INDEX_WIDTH-1:0]  TABLE_INDEX_B,
	output logic                         CARRY_A,
	output logic                         CARRY_B,
	output logic      [15:0]             LOOP_COUNT
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	synth_pkg::synth_state_t s_q;
	synth_pkg::synth_state_t s_d;

	logic                    step_a;
	logic                    step_b;
	logic [ACCUM_WIDTH-1:0]  phase_accum_a;
	logic [ACCUM_WIDTH-1:0]  phase_accum_b;
	logic [INDEX_WIDTH-1:0]  table_index_a;
	logic [INDEX_WIDTH-1:0]  table_index_b;
	logic                    carry_a;
	logic                    carry_b;
	logic [SAMPLE_WIDTH-1:0] sine_a;
	logic [SAMPLE_WIDTH-1:0] sine_b;

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	// (RULE1) channel a steps once per loop
	assign step_a = (s_q.state == synth_pkg::ST_STEP_A);
	// (RULE2) channel b steps once per loop
	assign step_b = (s_q.state == synth_pkg::ST_STEP_B);

	// (RULE9) index a preset sampled during reset
	phase_channel #(
		.ACCUM_WIDTH (ACCUM_WIDTH),
		.INDEX_WIDTH (INDEX_WIDTH)
	) u_chan_a (
		.clk         (REF_CLK),
		.srst        (SRST),
		.step_en     (step_a),
		.step_const  (STEP_CONST_A),
		.start_index (START_INDEX_A),
		.accum       (phase_accum_a),
		.index       (table_index_a),
		.carry       (carry_a)
	);

	// (RULE8) index b always clears at start-up
	phase_channel #(
		.ACCUM_WIDTH (ACCUM_WIDTH),
		.INDEX_WIDTH (INDEX_WIDTH)
	) u_chan_b (
		.clk         (REF_CLK),
		.srst        (SRST),
		.step_en     (step_b),
		.step_const  (STEP_CONST_B),
		.start_index (INDEX_WIDTH'(synth_pkg::INDEX_RESET)),
		.accum       (phase_accum_b),
		.index       (table_index_b),
		.carry       (carry_b)
	);

	// ----------------------------------------------------------------
	// table lookup
	// ----------------------------------------------------------------
	// (RULE7) sixteen-entry sine lookup
	assign sine_a = synth_pkg::SINE_TABLE[table_index_a];
	assign sine_b = synth_pkg::SINE_TABLE[table_index_b];

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// one step per state and no branch on carry, so the loop never
	// stretches; the price is an idle load slot we could have merged
	always_comb begin
		s_d        = s_q;
		s_d.strobe = 1'b0;
		case (s_q.state)
			synth_pkg::ST_INIT: begin
				// (RULE8) drivers on before the first loop
				s_d.oe       = synth_pkg::OE_DRIVE;
				s_d.work_sum = synth_pkg::SUM_RESET;
				s_d.state    = synth_pkg::ST_STEP_A;
			end
			synth_pkg::ST_STEP_A: begin
				s_d.state = synth_pkg::ST_LOAD;
			end
			synth_pkg::ST_LOAD: begin
				// (RULE3) sum starts from channel a
				s_d.work_sum = sine_a;
				s_d.state    = synth_pkg::ST_STEP_B;
			end
			synth_pkg::ST_STEP_B: begin
				s_d.state = synth_pkg::ST_MIX;
			end
			synth_pkg::ST_MIX: begin
				// (RULE4) channel b added in
				// (RULE13) peak entries keep this add in range
				s_d.work_sum = s_q.work_sum + sine_b;
				s_d.state    = synth_pkg::ST_DRIVE;
			end
			synth_pkg::ST_DRIVE: begin
				// (RULE5) sum out to the converter
				s_d.port   = s_q.work_sum;
				s_d.strobe = 1'b1;
				s_d.loops  = s_q.loops + 1'b1;
				// (RULE6) straight back, fixed length
				s_d.state  = synth_pkg::ST_STEP_A;
			end
			default: begin
				s_d.state = synth_pkg::ST_INIT;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			// (RULE8) everything cleared, port released
			s_q.state    <= synth_pkg::ST_INIT;
			s_q.work_sum <= synth_pkg::SUM_RESET;
			s_q.port     <= synth_pkg::SUM_RESET;
			s_q.oe       <= synth_pkg::OE_RESET;
			s_q.strobe   <= 1'b0;
			s_q.loops    <= synth_pkg::COUNT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign DAC_OUTPUT_PORT = s_q.port;
	assign DAC_OUTPUT_OE   = s_q.oe;
	assign SAMPLE_STROBE   = s_q.strobe;
	assign LOOP_COUNT      = s_q.loops;
	// (RULE10) both indices visible for tone checks
	assign TABLE_INDEX_A   = table_index_a;
	assign TABLE_INDEX_B   = table_index_b;
	// (RULE11) carries visible one cycle after the add
	assign CARRY_A         = carry_a;
	assign CARRY_B         = carry_b;

endmodule : sine_synth

`default_nettype wire

// [bench/ladder_dac.sv]
`default_nettype none

module ladder_dac (
	// converter pins
	input  wire logic [7:0] data,
	input  wire logic [7:0] oe,
	// settled ladder code
	output logic      [7:0] level
);
	timeunit 1ns;
	timeprecision 100ps;
	// undriven pins float: show the inverse so a stale match cannot pass
	assign level = (oe == 8'hFF) ? data : ~data;
endmodule : ladder_dac

`default_nettype wire

// [bench/sine_synth_chk.sv]
`default_nettype none

module sine_synth_chk (
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        SRST,
	// watched ports
	input wire logic [3:0]  START_INDEX_A,
	input wire logic [7:0]  DAC_OUTPUT_PORT,
	input wire logic [7:0]  DAC_OUTPUT_OE,
	input wire logic        SAMPLE_STROBE,
	input wire logic [3:0]  TABLE_INDEX_A,
	input wire logic [3:0]  TABLE_INDEX_B,
	input wire logic        CARRY_A,
	input wire logic        CARRY_B,
	input wire logic [15:0] LOOP_COUNT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	reset_clear_a: assert property (disable iff (1'b0) SRST |=>
		DAC_OUTPUT_PORT == 8'h00 && DAC_OUTPUT_OE == 8'h00 && !SAMPLE_STROBE
		&& LOOP_COUNT == 16'h0000 && TABLE_INDEX_B == 4'h0) else $error("reset");
	preset_take_a: assert property (disable iff (1'b0) SRST |=>
		TABLE_INDEX_A == $past(START_INDEX_A)) else $error("preset");
	oe_drive_a: assert property (!SRST |=> DAC_OUTPUT_OE == 8'hFF)
		else $error("oe");
	first_loop_a: assert property ($fell(SRST) |->
		!SAMPLE_STROBE [*6] ##1 SAMPLE_STROBE) else $error("first loop");
	loop_period_a: assert property (SAMPLE_STROBE |=>
		!SAMPLE_STROBE [*4] ##1 SAMPLE_STROBE) else $error("period");
	port_hold_a: assert property (!SAMPLE_STROBE |->
		$stable(DAC_OUTPUT_PORT)) else $error("port hold");
	mix_range_a: assert property (SAMPLE_STROBE |->
		DAC_OUTPUT_PORT inside {[8'h02:8'hFE]}) else $error("range");
	step_index_a: assert property ($changed(TABLE_INDEX_A) |->
		CARRY_A && TABLE_INDEX_A == 4'($past(TABLE_INDEX_A) + 4'h1))
		else $error("index a");
	step_index_b_a: assert property ($changed(TABLE_INDEX_B) |->
		CARRY_B && TABLE_INDEX_B == 4'($past(TABLE_INDEX_B) + 4'h1))
		else $error("index b");
	carry_slot_a: assert property (CARRY_A |-> ##4 SAMPLE_STROBE)
		else $error("carry a slot");
	carry_slot_b_a: assert property (CARRY_B |-> ##2 SAMPLE_STROBE)
		else $error("carry b slot");
	loop_count_a: assert property (LOOP_COUNT ==
		16'($past(LOOP_COUNT) + 16'(SAMPLE_STROBE))) else $error("count");

	cover property (CARRY_A);
	cover property (SAMPLE_STROBE && DAC_OUTPUT_PORT == 8'h80);
	cover property (CARRY_B && TABLE_INDEX_B == 4'h0);
endmodule : sine_synth_chk

bind sine_synth sine_synth_chk sine_synth_chk_i (.REF_CLK(REF_CLK),
	.SRST(SRST), .START_INDEX_A(START_INDEX_A),
	.DAC_OUTPUT_PORT(DAC_OUTPUT_PORT), .DAC_OUTPUT_OE(DAC_OUTPUT_OE),
	.SAMPLE_STROBE(SAMPLE_STROBE), .TABLE_INDEX_A(TABLE_INDEX_A),
	.TABLE_INDEX_B(TABLE_INDEX_B), .CARRY_A(CARRY_A), .CARRY_B(CARRY_B),
	.LOOP_COUNT(LOOP_COUNT));

`default_nettype wire

// [bench/test_sine_synth.sv]
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	err_total++; $display("[ERR] %0t got %h want %h", $time, a, b); end end

module test_sine_synth;
	timeunit 1ns;
	timeprecision 100ps;

	logic        ref_clk = 1'b0;
	logic        srst    = 1'b1;
	logic [7:0]  ca      = 8'h00;
	logic [7:0]  cb      = 8'h00;
	logic [3:0]  sa      = 4'h0;
	logic [7:0]  port, oe, level;
	logic        strobe, cy_a, cy_b;
	logic [3:0]  ix_a, ix_b, xa, xb;
	logic [15:0] cnt, n_loops;
	logic [8:0]  sum_a, sum_b;
	int          err_total = 0, samples_checked = 0, seed = 55519;

	always #5 ref_clk = ~ref_clk;

	sine_synth sine_synth_i (.REF_CLK(ref_clk), .SRST(srst),
		.STEP_CONST_A(ca), .STEP_CONST_B(cb), .START_INDEX_A(sa),
		.DAC_OUTPUT_PORT(port), .DAC_OUTPUT_OE(oe), .SAMPLE_STROBE(strobe),
		.TABLE_INDEX_A(ix_a), .TABLE_INDEX_B(ix_b), .CARRY_A(cy_a),
		.CARRY_B(cy_b), .LOOP_COUNT(cnt));
	ladder_dac ladder_dac_i (.data(port), .oe(oe), .level(level));

	// ------------------------------------------------------------
	// expectation and drivers
	// ------------------------------------------------------------
	function automatic logic [7:0] sine(input logic [3:0] k);
		return 8'($rtoi(64.0 + 63.0 * $sin(k * 3.14159265 / 8.0) + 0.5));
	endfunction : sine

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick

	task automatic start(input logic [3:0] s);
		srst = 1'b1;
		sa = s;
		repeat (16) tick();
		`CHK(oe, 8'h00)
		`CHK(ix_a, s)
		srst = 1'b0;
		{sum_a, sum_b, xa, xb, n_loops} = {18'h0, s, 4'h0, 16'h0};
	endtask : start

	task automatic run(input int n, input logic [7:0] a, b, input bit rnd);
		int w;
		// first loop spends one extra edge leaving reset
		w = (n_loops == 16'h0000) ? 6 : 5;
		repeat (n) begin
			ca = rnd ? 8'($random(seed)) : a;
			cb = rnd ? 8'($random(seed)) : b;
			sum_a = 9'(sum_a[7:0]) + 9'(ca);
			sum_b = 9'(sum_b[7:0]) + 9'(cb);
			xa = xa + 4'(sum_a[8]);
			xb = xb + 4'(sum_b[8]);
			n_loops++;
			repeat (w) tick();
			w = 5;
			`CHK(strobe, 1'b1)
			`CHK(level, 8'(sine(xa) + sine(xb)))
			`CHK({ix_a, ix_b}, {xa, xb})
			`CHK(cnt, n_loops)
			`CHK(oe, 8'hFF)
		end
	endtask : run

	task automatic results();
		$display("checked %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		start(4'h0);
		run(40, 8'h00, 8'h00, 1'b1);
		run(30, 8'h64, 8'h64, 1'b0);
		// reset in mid-run, half-cycle preset cancels the tone
		start(4'h8);
		run(20, 8'h64, 8'h64, 1'b0);
		start(4'hF);
		run(30, 8'hFF, 8'h01, 1'b0);
		results();
	end

	initial begin
		#20000;
		err_total++;
		results();
	end
endmodule : test_sine_synth

`default_nettype wire
